// ---- rev_slew_cfg.sv ----
// Register bank for reverse-current flags and setpoint slew, two channels.
// Assumes a one-cycle strobe register port and sense samples on core_clk.
module rev_slew_cfg
	import rev_slew_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sense inputs
	input wire logic signed [SENSE_W-1:0] secondary_current_sense_a,
	input wire logic signed [SENSE_W-1:0] secondary_current_sense_b,
	// Flags and outputs
	output logic rev_flag_a,
	output logic rev_flag_b,
	output logic [7:0] chan_a_setpoint,
	output logic [7:0] chan_b_setpoint,
	output logic irq
);
	logic [7:0] chan_a_reverse_current_cfg_q;
	logic [7:0] chan_b_reverse_current_cfg_q;
	logic [7:0] chan_a_voltage_slew_cfg_q;
	logic [7:0] chan_b_voltage_slew_cfg_q;
	logic [7:0] target_a_q;
	logic [7:0] target_b_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic flag_a;
	logic flag_b;
	logic [1:0] flag_prev_q;
	logic [7:0] vout_a;
	logic [7:0] vout_b;

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			chan_a_reverse_current_cfg_q <= REV_RESET;
			chan_b_reverse_current_cfg_q <= REV_RESET;
			chan_a_voltage_slew_cfg_q <= SLEW_RESET;
			chan_b_voltage_slew_cfg_q <= SLEW_RESET;
			target_a_q <= SETPT_RESET;
			target_b_q <= SETPT_RESET;
			irq_mask_q <= 2'h0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				ADDR_REV_A: chan_a_reverse_current_cfg_q <= reg_wdata;
				ADDR_REV_B: chan_b_reverse_current_cfg_q <= reg_wdata;
				ADDR_SLEW_A: chan_a_voltage_slew_cfg_q <= reg_wdata;
				ADDR_SLEW_B: chan_b_voltage_slew_cfg_q <= reg_wdata;
				ADDR_SETPT_A: target_a_q <= reg_wdata;
				ADDR_SETPT_B: target_b_q <= reg_wdata;
				ADDR_IRQ_MASK: irq_mask_q <= reg_wdata[1:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// Channel logic
	// ****************************************
	rev_flag_chan u_flag_a (
		.core_clk(core_clk),
		.rst(rst),
		.cfg(chan_a_reverse_current_cfg_q),
		.sense(secondary_current_sense_a),
		.flag(flag_a)
	);

	rev_flag_chan u_flag_b (
		.core_clk(core_clk),
		.rst(rst),
		.cfg(chan_b_reverse_current_cfg_q),
		.sense(secondary_current_sense_b),
		.flag(flag_b)
	);

	slew_chan u_slew_a (
		.core_clk(core_clk),
		.rst(rst),
		.cfg(chan_a_voltage_slew_cfg_q),
		.target(target_a_q),
		.vout(vout_a)
	);

	slew_chan u_slew_b (
		.core_clk(core_clk),
		.rst(rst),
		.cfg(chan_b_voltage_slew_cfg_q),
		.target(target_b_q),
		.vout(vout_b)
	);

	// ****************************************
	// Outputs and interrupt
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rev_flag_a <= 1'b0;
			rev_flag_b <= 1'b0;
			chan_a_setpoint <= SETPT_RESET;
			chan_b_setpoint <= SETPT_RESET;
			flag_prev_q <= 2'h0;
		end else begin
			rev_flag_a <= flag_a;
			rev_flag_b <= flag_b;
			chan_a_setpoint <= vout_a;
			chan_b_setpoint <= vout_b;
			flag_prev_q <= {flag_b, flag_a};
		end
	end

	// Rising flag sets status; set wins over write-one clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_stat_q <= 2'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == ADDR_IRQ_STAT) ? reg_wdata[1:0] : 2'h0))
				| ({flag_b, flag_a} & ~flag_prev_q);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_REV_A: reg_rdata <= chan_a_reverse_current_cfg_q;
				ADDR_REV_B: reg_rdata <= chan_b_reverse_current_cfg_q;
				ADDR_SLEW_A: reg_rdata <= chan_a_voltage_slew_cfg_q;
				ADDR_SLEW_B: reg_rdata <= chan_b_voltage_slew_cfg_q;
				ADDR_SETPT_A: reg_rdata <= target_a_q;
				ADDR_SETPT_B: reg_rdata <= target_b_q;
				ADDR_VOUT_A: reg_rdata <= vout_a;
				ADDR_VOUT_B: reg_rdata <= vout_b;
				ADDR_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_q};
				ADDR_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_q};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule // rev_slew_cfg

// ---- rev_slew_pkg.sv ----
// Constants, register map and timing for the reverse-current and slew configuration block.
// Assumes one 100 MHz clock and a plain one-cycle strobe register port.
// How it works
// - Two reverse-current config bytes, A then B
// - Bit 3 picks 40 ns or 200 ns
// - Flag after debounce when current below threshold
// - Bits 2:0 threshold code, 00x reserved
// - Slew bits 3:1, code 0 four steps/ms
// - Enable bit 0 ramps setpoint at rate
package rev_slew_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
	localparam logic [15:0] ADDR_REV_A = 16'hFE84;
	localparam logic [15:0] ADDR_REV_B = 16'hFE85;
	localparam logic [15:0] ADDR_SLEW_A = 16'hFE86;
	localparam logic [15:0] ADDR_SLEW_B = 16'hFE87;
	localparam logic [15:0] ADDR_IRQ_STAT = 16'hFE90;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'hFE91;
	localparam logic [15:0] ADDR_SETPT_A = 16'hFE92;
	localparam logic [15:0] ADDR_SETPT_B = 16'hFE93;
	localparam logic [15:0] ADDR_VOUT_A = 16'hFE94;
	localparam logic [15:0] ADDR_VOUT_B = 16'hFE95;
	localparam logic [7:0] REV_RESET = 8'h00;
	localparam logic [7:0] SLEW_RESET = 8'h00;
	localparam logic [7:0] SETPT_RESET = 8'h00;
	localparam int unsigned DEB_SEL_BIT = 3;
	localparam int unsigned SLEW_EN_BIT = 0;
	localparam int unsigned SLEW_LO = 1;
	localparam int unsigned SLEW_HI = 3;
	localparam logic [1:0] THR_RESERVED_TOP = 2'h0;
	// Debounce times in ns, converted to cycles rounding up
	localparam int unsigned DEB_SHORT_NS = 40;
	localparam int unsigned DEB_LONG_NS = 200;
	localparam int unsigned DEB_SHORT_CYC = (DEB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DEB_LONG_CYC = (DEB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DEB_W = 5;
	// Slowest slew step interval: 4 steps per ms, 250 us per step
	localparam int unsigned SLOW_STEP_US = 250;
	localparam int unsigned SLOW_STEP_CYC = SLOW_STEP_US * CLK_MHZ;
	localparam int unsigned STEP_W = 15;
	localparam int unsigned SENSE_W = 12;
	// Threshold magnitudes in sense LSB (one LSB per mV), codes 2..7
	localparam logic [11:0] THR_MV_2 = 12'h00A;
	localparam logic [11:0] THR_MV_3 = 12'h00D;
	localparam logic [11:0] THR_MV_4 = 12'h011;
	localparam logic [11:0] THR_MV_5 = 12'h014;
	localparam logic [11:0] THR_MV_6 = 12'h018;
	localparam logic [11:0] THR_MV_7 = 12'h01B;
endpackage

// ---- rev_flag_chan.sv ----
// One channel of reverse-current flag detection with debounce.
// Assumes the sense sample is signed, in mV LSB, on the core clock.
module rev_flag_chan
	import rev_slew_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Configuration
	input wire logic [7:0] cfg,
	// Sense sample
	input wire logic signed [SENSE_W-1:0] sense,
	// Flag
	output logic flag
);
	logic signed [SENSE_W-1:0] thr;
	logic below;
	logic [DEB_W-1:0] cnt_q;
	logic [DEB_W-1:0] limit;

	always_comb begin
		unique case (cfg[2:0])
			3'h2: thr = -$signed(THR_MV_2);
			3'h3: thr = -$signed(THR_MV_3);
			3'h4: thr = -$signed(THR_MV_4);
			3'h5: thr = -$signed(THR_MV_5);
			3'h6: thr = -$signed(THR_MV_6);
			3'h7: thr = -$signed(THR_MV_7);
			default: thr = -$signed(THR_MV_2);
		endcase
	end

	assign below = (cfg[2:1] != THR_RESERVED_TOP) && (sense < thr);
	assign limit = cfg[DEB_SEL_BIT] ? DEB_W'(DEB_LONG_CYC) : DEB_W'(DEB_SHORT_CYC);

	// ****************************************
	// Debounce counter
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst || !below) begin
			cnt_q <= '0;
			flag <= 1'b0;
		end else if (cnt_q >= limit - DEB_W'(1)) begin
			flag <= 1'b1;
		end else begin
			cnt_q <= cnt_q + DEB_W'(1);
		end
	end
endmodule // rev_flag_chan

// ---- slew_chan.sv ----
// One channel of output setpoint slew ramping.
// Assumes one LSB step per enable pulse.
module slew_chan
	import rev_slew_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Configuration
	input wire logic [7:0] cfg,
	input wire logic [7:0] target,
	// Ramped output
	output logic [7:0] vout
);
	logic [STEP_W-1:0] div_q;
	logic [STEP_W-1:0] interval;
	logic step;

	// Interval halves with each higher code
	assign interval = STEP_W'(SLOW_STEP_CYC >> cfg[SLEW_HI:SLEW_LO]);
	assign step = (div_q >= interval - STEP_W'(1));

	always_ff @(posedge core_clk) begin
		if (rst || step) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + STEP_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			vout <= SETPT_RESET;
		end else if (!cfg[SLEW_EN_BIT]) begin
			vout <= target;
		end else if (step && vout < target) begin
			vout <= vout + 8'h01;
		end else if (step && vout > target) begin
			vout <= vout - 8'h01;
		end
	end
endmodule // slew_chan

// ---- rev_slew_cfg_sva.sv ----
// Port checker for rev_slew_cfg.
// Assumes binding into rev_slew_cfg, one clock.
// ****
// Checker
// ****
module rev_slew_cfg_sva
	import rev_slew_pkg::*;
(
	// Clock, reset, bus
	input wire logic core_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Sense and outputs
	input wire logic signed [SENSE_W-1:0] secondary_current_sense_a,
	input wire logic signed [SENSE_W-1:0] secondary_current_sense_b,
	input wire logic rev_flag_a,
	input wire logic rev_flag_b,
	input wire logic [7:0] chan_a_setpoint,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	AST_FA_HOLD: assert property (rev_flag_a |-> $past(secondary_current_sense_a, 2) < -10)
		else $error("flag a without cause");
	AST_FB_HOLD: assert property (rev_flag_b |-> $past(secondary_current_sense_b, 2) < -10)
		else $error("flag b without cause");
	AST_FA_DEB: assert property ($rose(rev_flag_a) |-> $past(secondary_current_sense_a, 5) < -10)
		else $error("flag a too early");
	AST_FB_DEB: assert property ($rose(rev_flag_b) |-> $past(secondary_current_sense_b, 5) < -10)
		else $error("flag b too early");
	AST_IRQ_SET: assert property ($rose(irq) |-> $past(rev_flag_a | rev_flag_b) || $past(reg_wr, 2))
		else $error("irq without event");
	AST_IRQ_CLR: assert property ($fell(irq) |-> $past(reg_wr, 2))
		else $error("irq dropped alone");
	AST_SPA_STEP: assert property ($changed(chan_a_setpoint) && !$past(reg_wr, 2) && !$past(reg_wr, 3) |->
		chan_a_setpoint == $past(chan_a_setpoint) + 8'h01 || chan_a_setpoint == $past(chan_a_setpoint) - 8'h01)
		else $error("setpoint step not one");
endmodule // rev_slew_cfg_sva
bind rev_slew_cfg rev_slew_cfg_sva u_sva (.core_clk, .rst, .reg_wr, .reg_rd, .reg_rdata, .secondary_current_sense_a,
	.secondary_current_sense_b, .rev_flag_a, .rev_flag_b, .chan_a_setpoint, .irq);

// ---- rev_slew_cfg_tb_top.sv ----
// Bench for rev_slew_cfg: registers, flags, interrupt, slew.
// Assumes the design package and the bound checker.
module rev_slew_cfg_tb_top
	import rev_slew_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Signals and design
	// ****
	logic core_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fa, fb, irq;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wd = 8'h00, rdata, spa, spb;
	logic signed [SENSE_W-1:0] sa = '0, sb = '0;
	int mismatches = 0, checks = 0, cyc = 0;
	int mv[8] = '{100, 100, 10, 13, 17, 20, 24, 27};
	rev_slew_cfg u_dut (.core_clk, .rst, .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .secondary_current_sense_a(sa), .secondary_current_sense_b(sb), .rev_flag_a(fa),
		.rev_flag_b(fb), .chan_a_setpoint(spa), .chan_b_setpoint(spb), .irq);
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			mismatches++;
			finish_test();
		end
	end
	// ****
	// Tasks
	// ****
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %0h got %0h", n, e, s);
		end
	endtask
	task automatic ticks(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr_reg(logic [15:0] a, logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(string n, logic [15:0] a, logic [7:0] e);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		chk(n, e, rdata);
	endtask
	task automatic t_regs();
		for (int i = 0; i < 4; i++)
			rd_chk("cfg reset", ADDR_REV_A + 16'(i), 8'h00);
		for (int i = 0; i < 4; i++)
			wr_reg(ADDR_REV_A + 16'(i), 8'hA0 + 8'(i));
		for (int i = 0; i < 4; i++)
			rd_chk("cfg readback", ADDR_REV_A + 16'(i), 8'hA0 + 8'(i));
		rd_chk("unmapped", 16'hFE8F, 8'h00);
		$display("register test done");
	endtask
	task automatic t_deb(logic ch, logic [7:0] cfg, int n);
		int k;
		k = 0;
		wr_reg(ch ? ADDR_REV_B : ADDR_REV_A, cfg);
		@(posedge core_clk);
		if (ch)
			sb <= -12'sd30;
		else
			sa <= -12'sd30;
		while ((ch ? fb : fa) !== 1'b1 && k < 40) begin
			ticks(1);
			k++;
		end
		chk("flag delay", 16'(n + 1), 16'(k));
		@(posedge core_clk);
		sa <= '0;
		sb <= '0;
		ticks(3);
		chk("flag clear", 16'h0000, ch ? fb : fa);
		$display("debounce test done");
	endtask
	task automatic t_irq();
		chk("irq masked", 16'h0000, irq);
		wr_reg(ADDR_IRQ_MASK, 8'h03);
		ticks(2);
		chk("irq raised", 16'h0001, irq);
		rd_chk("status", ADDR_IRQ_STAT, 8'h03);
		wr_reg(ADDR_IRQ_STAT, 8'h03);
		ticks(2);
		chk("irq cleared", 16'h0000, irq);
		rd_chk("status clear", ADDR_IRQ_STAT, 8'h00);
		$display("irq test done");
	endtask
	task automatic t_thr(logic [2:0] c);
		wr_reg(ADDR_REV_A, {5'h00, c});
		@(posedge core_clk);
		sa <= 12'(-mv[c]);
		ticks(8);
		chk("at threshold", 16'h0000, fa);
		@(posedge core_clk);
		sa <= 12'(-mv[c] - 1);
		ticks(8);
		chk("below threshold", 16'(c > 3'h1), fa);
		@(posedge core_clk);
		sa <= '0;
		ticks(3);
		$display("threshold test done");
	endtask
	task automatic t_slew(logic [2:0] c, logic dn);
		logic [7:0] w;
		logic [7:0] t;
		int k;
		t = dn ? spa - 8'h02 : spa + 8'h02;
		wr_reg(ADDR_SLEW_A, {4'h0, c, 1'b1});
		wr_reg(ADDR_SETPT_A, t);
		for (int j = 0; j < 2; j++) begin
			w = spa;
			k = 0;
			while (spa === w && k < 30000) begin
				ticks(1);
				k++;
			end
		end
		chk("step interval", 16'(25000 >> c), 16'(k));
		chk("step dir", dn ? w - 8'h01 : w + 8'h01, spa);
		rd_chk("ramp out", ADDR_VOUT_A, dn ? w - 8'h01 : w + 8'h01);
		rd_chk("target", ADDR_SETPT_A, t);
		$display("slew test done");
	endtask
	task automatic t_direct();
		wr_reg(ADDR_SLEW_B, 8'hF0);
		wr_reg(ADDR_SETPT_B, 8'h5A);
		ticks(3);
		chk("direct setpoint", 16'h005A, spb);
		rd_chk("slew cfg b", ADDR_SLEW_B, 8'hF0);
		$display("direct test done");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ****
	// Sequence
	// ****
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_deb(1'b0, 8'hF2, 4);
		t_deb(1'b1, 8'h0F, 20);
		t_irq();
		for (int i = 0; i < 8; i++)
			t_thr(3'(i));
		t_slew(3'h7, 1'b0);
		t_slew(3'h7, 1'b1);
		t_slew(3'h4, 1'b0);
		t_slew(3'h1, 1'b0);
		t_direct();
		finish_test();
	end
endmodule // rev_slew_cfg_tb_top
